// file: acc_ctrl.sv
`timescale 1ns/1ps
// ==========================================================
// Summary of operation
// - Channel field changes during a conversion apply only after it completes.
// - Codes 0..7 route single-ended inputs 0..7.
// - Codes 32,33,34 select ground, 1.1V reference, temperature (sensor enabled).
// - Codes 8..31 are differential pairs; 40..63 the same pairs reversed.
// - Differential codes use bit 0 as gain: 0 gives 1x, 1 gives 20x.
// - Top bit swaps positive and negative on normal differential pairs.
// - Offset-calibration codes 35,36,38 tie inputs 0,3,7 to both sides.
// - Each differential code decodes to its tabulated pin pair.
// - Enable bit one turns the converter on, zero turns it off.
// - Clearing enable aborts a running conversion at once.
// - Start launches one conversion; free running chains further ones.
// - First conversion after enable takes 25 converter clocks, later 13.
// - Start reads one while busy; writing zero to it does nothing.
// - Control A holds enable,start,auto,done,irq-en,prescale; resets zero.
// - Done flag sets at completion, clears on vector ack or write one.
// - Prescale codes 0 and 1 divide by 2, then doubling up to 128.
// - With auto trigger set, a rising trigger edge seen while idle starts a conversion; edges during a conversion are ignored.
// ==========================================================
module acc_ctrl
    import acc_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    // Wishbone classic slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Trigger source (asynchronous) and interrupt vector acknowledge
    input wire logic trigger_in,
    input wire logic vector_ack_in,
    // Analog front end
    output acc_pkg::acc_mux_t mux_out,
    output logic conv_run_out,
    output logic sample_out,
    output logic conv_end_out,
    output logic done_irq_out
);
    import acc_pkg::*;

    // ==========================================================
    // Registers
    // ==========================================================
    logic en_r, ate_r, done_r, ie_r;
    logic [2:0] ps_r;
    logic [5:0] chsel_r;
    logic [1:0] chref_r;
    logic free_run_r;
    logic trig_s1_r, trig_s2_r, trig_d_r;
    logic first_r;
    logic [6:0] pre_cnt_r;
    logic [4:0] cyc_cnt_r;
    logic [4:0] cyc_len_r;
    acc_state_t state_r;
    acc_mux_t mux_r;
    logic ack_r;
    logic [31:0] rdat_r;

    logic access, wr, wr_ctrl, start_req, trig_rise, conv_tick, finish;
    logic [6:0] div_mask;

    // A request is taken once: ack blocks the following cycle, so a strobe
    // still held while the master sees ack is never taken as a second access
    assign access = wb_cyc_in & wb_stb_in & ~ack_r;
    assign wr = access & wb_we_in & wb_sel_in[0];
    assign wr_ctrl = wr && (wb_adr_in == ACC_CTRL_A_OFF);

    // ==========================================================
    // Channel decode
    // ==========================================================
    function automatic acc_src_t pin(input logic [2:0] n);
        return acc_src_t'({1'b0, n});
    endfunction

    // Priority follows the code map: single-ended first, then the three fixed
    // sources, then offset calibration, and whatever is left is a pair.
    // Reserved codes 37 and 39 fall into the offset-calibration decode rather than leaving the mux open.
    function automatic acc_mux_t decode(input logic [5:0] c);
        acc_mux_t m;
        logic [4:0] pair;
        m = '{pos: ACC_SRC_GND, neg: ACC_SRC_GND, diff: 1'b0, gain20: 1'b0, temp_en: 1'b0};
        pair = {c[4:1], 1'b0};
        if (c[5:3] == 3'b000) begin
            m.pos = pin(c[2:0]);
        end else if (c == ACC_CH_GND) begin
            m.pos = ACC_SRC_GND;
        end else if (c == ACC_CH_REF) begin
            m.pos = ACC_SRC_REF;
        end else if (c == ACC_CH_TEMP) begin
            m.pos = ACC_SRC_TEMP;
            m.temp_en = 1'b1;
        end else if (c[5:3] == 3'b100) begin
            // Offset calibration: same pin on both sides
            m.diff = 1'b1;
            m.gain20 = (c[2:0] == 3'b011) | c[0];
            case (c[2:1])
                2'b01: m.pos = ACC_SRC_IN0;
                2'b10: m.pos = ACC_SRC_IN3;
                default: m.pos = ACC_SRC_IN7;
            endcase
            m.neg = m.pos;
        end else begin
            m.diff = 1'b1;
            m.gain20 = c[0];
            // Pair table by c[4:1] for codes 8..31
            case (pair)
                5'd8: begin m.pos = ACC_SRC_IN0; m.neg = ACC_SRC_IN1; end
                5'd10: begin m.pos = ACC_SRC_IN0; m.neg = ACC_SRC_IN3; end
                5'd12: begin m.pos = ACC_SRC_IN1; m.neg = ACC_SRC_IN2; end
                5'd14: begin m.pos = ACC_SRC_IN1; m.neg = ACC_SRC_IN3; end
                5'd16: begin m.pos = ACC_SRC_IN2; m.neg = ACC_SRC_IN3; end
                5'd18: begin m.pos = ACC_SRC_IN3; m.neg = ACC_SRC_IN4; end
                5'd20: begin m.pos = ACC_SRC_IN3; m.neg = ACC_SRC_IN5; end
                5'd22: begin m.pos = ACC_SRC_IN3; m.neg = ACC_SRC_IN6; end
                5'd24: begin m.pos = ACC_SRC_IN3; m.neg = ACC_SRC_IN7; end
                5'd26: begin m.pos = ACC_SRC_IN4; m.neg = ACC_SRC_IN5; end
                5'd28: begin m.pos = ACC_SRC_IN5; m.neg = ACC_SRC_IN6; end
                default: begin m.pos = ACC_SRC_IN6; m.neg = ACC_SRC_IN7; end
            endcase
            if (c[5]) begin
                // Reversed pair
                m.pos = m.neg;
                m.neg = decode_pos(pair);
            end
        end
        return m;
    endfunction

    // Positive side of a normal pair; the reversed codes need it as their
    // negative side, so it is kept apart from the main table
    function automatic acc_src_t decode_pos(input logic [4:0] pair);
        case (pair)
            5'd8, 5'd10: return ACC_SRC_IN0;
            5'd12, 5'd14: return ACC_SRC_IN1;
            5'd16: return ACC_SRC_IN2;
            5'd18, 5'd20, 5'd22, 5'd24: return ACC_SRC_IN3;
            5'd26: return ACC_SRC_IN4;
            5'd28: return ACC_SRC_IN5;
            default: return ACC_SRC_IN6;
        endcase
    endfunction

    // ==========================================================
    // Prescaler
    // ==========================================================
    function automatic logic [6:0] ps_mask(input logic [2:0] s);
        // Divide by 2^max(s,1); mask holds divisor minus one
        return (s == 3'd0) ? 7'h01 : 7'((8'h01 << s) - 8'h01);
    endfunction

    // Held at zero outside a conversion so each one starts on a fresh phase;
    // the cost is that the divider cannot be shared with other users
    assign div_mask = ps_mask(ps_r);
    assign conv_tick = en_r && (pre_cnt_r == div_mask);

    always_ff @(posedge mclk_in) begin
        if (rst_in || !en_r || state_r != ACC_CONV) begin
            pre_cnt_r <= 7'h00;
        end else if (conv_tick) begin
            pre_cnt_r <= 7'h00;
        end else begin
            pre_cnt_r <= pre_cnt_r + 7'h01;
        end
    end

    // ==========================================================
    // Trigger edge (external domain, two flops first)
    // ==========================================================
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_d_r <= 1'b0;
        end else begin
            trig_s1_r <= trigger_in;
            trig_s2_r <= trig_s1_r;
            trig_d_r <= trig_s2_r;
        end
    end
    // Edge taken from the second stage only; a pulse shorter than one clock
    // may be lost, a limitation the trigger source must respect
    assign trig_rise = trig_s2_r & ~trig_d_r;

    // Start from software (write one only) or auto trigger edge
    assign start_req = (wr_ctrl && wb_dat_in[ACC_START_BIT])
        || (ate_r && trig_rise);

    // ==========================================================
    // Conversion sequencer
    // ==========================================================
    // Completion on the last converter tick of the chosen length; the done state
    // lasts one clock so the end pulse and the flag set line up
    // Disable has priority over every state so an abort is never deferred
    assign finish = (state_r == ACC_CONV) && conv_tick && (cyc_cnt_r == cyc_len_r - 5'd1);

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_r <= ACC_IDLE;
            cyc_cnt_r <= 5'd0;
            cyc_len_r <= ACC_SHORT_CYC;
            first_r <= 1'b1;
        end else if (wr_ctrl && !wb_dat_in[ACC_EN_BIT]) begin
            state_r <= ACC_IDLE;
            first_r <= 1'b1;
            cyc_cnt_r <= 5'd0;
        end else begin
            case (state_r)
                ACC_IDLE: begin
                    // Enable may arrive in the same write as start
                    if (start_req && (en_r || (wr_ctrl && wb_dat_in[ACC_EN_BIT]))) begin
                        state_r <= ACC_CONV;
                        cyc_cnt_r <= 5'd0;
                        cyc_len_r <= first_r ? ACC_LONG_CYC : ACC_SHORT_CYC;
                        first_r <= 1'b0;
                    end
                end
                ACC_CONV: begin
                    if (finish) begin
                        state_r <= ACC_DONE;
                    end else if (conv_tick) begin
                        cyc_cnt_r <= cyc_cnt_r + 5'd1;
                    end
                end
                default: begin
                    // Free running re-arms with a short conversion
                    if (free_run_r) begin
                        state_r <= ACC_CONV;
                        cyc_cnt_r <= 5'd0;
                        cyc_len_r <= ACC_SHORT_CYC;
                    end else begin
                        state_r <= ACC_IDLE;
                    end
                end
            endcase
        end
    end

    // Free running: auto trigger on and bit 0 of the trigger register written one
    // Dropping enable or auto trigger clears it, so a re-enable never chains
    // conversions unless software asks for it again
    always_ff @(posedge mclk_in) begin
        if (rst_in || !ate_r || !en_r) begin
            free_run_r <= 1'b0;
        end else if (wr && wb_adr_in == ACC_TRIG_OFF) begin
            free_run_r <= wb_dat_in[0];
        end
    end

    // ==========================================================
    // Control register A
    // ==========================================================
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            {en_r, ate_r, ie_r, ps_r} <= {ACC_CTRL_A_RST[7], ACC_CTRL_A_RST[5],
                ACC_CTRL_A_RST[3], ACC_CTRL_A_RST[2:0]};
        end else if (wr_ctrl) begin
            // Start and done are not stored here: start is the busy state and
            // done has its own set and clear logic below
            en_r <= wb_dat_in[ACC_EN_BIT];
            ate_r <= wb_dat_in[ACC_ATE_BIT];
            ie_r <= wb_dat_in[ACC_IE_BIT];
            ps_r <= wb_dat_in[2:0];
        end
    end

    // Set wins over both clears, so a completion racing a clear is not lost
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            done_r <= ACC_CTRL_A_RST[ACC_DONE_BIT];
        end else if (finish) begin
            done_r <= 1'b1;
        end else if (vector_ack_in || (wr_ctrl && wb_dat_in[ACC_DONE_BIT])) begin
            done_r <= 1'b0;
        end
    end

    // ==========================================================
    // Channel select and staged mux controls
    // ==========================================================
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            chsel_r <= ACC_CHSEL_RST[5:0];
            chref_r <= ACC_CHSEL_RST[7:6];
        end else if (wr && wb_adr_in == ACC_CHSEL_OFF) begin
            chsel_r <= wb_dat_in[5:0];
            chref_r <= wb_dat_in[7:6];
        end
    end

    // Held through a conversion so the front end never sees a mid-sample change
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            mux_r <= decode(ACC_CHSEL_RST[5:0]);
        end else if (state_r != ACC_CONV) begin
            mux_r <= decode(chsel_r);
        end
    end

    // ==========================================================
    // Wishbone read and ack
    // ==========================================================
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0;
        end else begin
            ack_r <= access;
            if (access && !wb_we_in) begin
                if (wb_adr_in == ACC_CTRL_A_OFF) begin
                    rdat_r <= {24'h0, en_r, state_r != ACC_IDLE, ate_r, done_r, ie_r, ps_r};
                end else if (wb_adr_in == ACC_CHSEL_OFF) begin
                    rdat_r <= {24'h0, chref_r, chsel_r};
                end else if (wb_adr_in == ACC_TRIG_OFF) begin
                    rdat_r <= {31'h0, free_run_r};
                end else if (wb_adr_in == ACC_STATUS_OFF) begin
                    // Bit 5 is unused and reads zero
                    rdat_r <= {19'h0, cyc_cnt_r, state_r, 1'b0, first_r, mux_r.pos};
                end else begin
                    rdat_r <= 32'h0;
                end
            end
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Run and end are decoded from the state register, so they change only on
    // clock edges and carry no glitch into the front end
    assign wb_ack_out = ack_r;
    assign wb_dat_out = rdat_r;
    assign mux_out = mux_r;
    assign conv_run_out = (state_r == ACC_CONV);
    assign sample_out = en_r;
    assign conv_end_out = (state_r == ACC_DONE);
    assign done_irq_out = done_r & ie_r;

endmodule // acc_ctrl

// file: acc_pkg.sv
package acc_pkg;

    // ==========================================================
    // Register map (word addresses on a 32-bit Wishbone bus)
    // ==========================================================
    localparam logic [7:0] ACC_CTRL_A_OFF = 8'h06;
    localparam logic [7:0] ACC_CHSEL_OFF = 8'h07;
    localparam logic [7:0] ACC_TRIG_OFF = 8'h08;
    localparam logic [7:0] ACC_STATUS_OFF = 8'h09;
    localparam int ACC_CTRL_A_IDX = 6;
    localparam int ACC_CHSEL_IDX = 7;
    localparam int ACC_TRIG_IDX = 8;
    localparam int ACC_STATUS_IDX = 9;

    // ==========================================================
    // Control register A fields
    // ==========================================================
    localparam int ACC_EN_BIT = 7;
    localparam int ACC_START_BIT = 6;
    localparam int ACC_ATE_BIT = 5;
    localparam int ACC_DONE_BIT = 4;
    localparam int ACC_IE_BIT = 3;
    localparam logic [7:0] ACC_CTRL_A_RST = 8'h00;
    localparam logic [7:0] ACC_CHSEL_RST = 8'h00;

    // ==========================================================
    // Channel codes and conversion lengths
    // ==========================================================
    localparam logic [5:0] ACC_CH_GND = 6'h20;
    localparam logic [5:0] ACC_CH_REF = 6'h21;
    localparam logic [5:0] ACC_CH_TEMP = 6'h22;
    localparam logic [4:0] ACC_LONG_CYC = 5'd25;
    localparam logic [4:0] ACC_SHORT_CYC = 5'd13;

    // Source selection presented to the analog multiplexer
    typedef enum logic [3:0] {
        ACC_SRC_IN0 = 4'h0, ACC_SRC_IN1 = 4'h1, ACC_SRC_IN2 = 4'h2, ACC_SRC_IN3 = 4'h3,
        ACC_SRC_IN4 = 4'h4, ACC_SRC_IN5 = 4'h5, ACC_SRC_IN6 = 4'h6, ACC_SRC_IN7 = 4'h7,
        ACC_SRC_GND = 4'h8, ACC_SRC_REF = 4'h9, ACC_SRC_TEMP = 4'ha
    } acc_src_t;

    typedef struct packed {
        acc_src_t pos;
        acc_src_t neg;
        logic diff;
        logic gain20;
        logic temp_en;
    } acc_mux_t;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_CONV = 2'b01,
        ACC_DONE = 2'b11
    } acc_state_t;

endpackage

// file: acc_ctrl_monitor.sv
`timescale 1ns/1ps
// ==========
// Bus and conversion sequencing checks
module acc_ctrl_monitor
    import acc_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic trigger_in,
    input wire logic vector_ack_in,
    input wire acc_pkg::acc_mux_t mux_out,
    input wire logic conv_run_out,
    input wire logic sample_out,
    input wire logic conv_end_out,
    input wire logic done_irq_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    logic take;
    logic wr_ctrl;
    assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wr_ctrl = take && wb_we_in && wb_sel_in[0] && (wb_adr_in == ACC_CTRL_A_OFF);

    ack_given_a: assert property (take |=> wb_ack_out)
        else $error("request not acknowledged");
    ack_single_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    enable_bit_a: assert property (wr_ctrl |=> sample_out == $past(wb_dat_in[7]))
        else $error("enable level does not follow write");
    start_run_a: assert property (wr_ctrl && wb_dat_in[7] && wb_dat_in[6]
        |=> ##[0:1] conv_run_out) else $error("start did not launch conversion");
    abort_run_a: assert property (wr_ctrl && !wb_dat_in[7] |=> ##[0:1] !conv_run_out)
        else $error("disable did not abort conversion");
    mux_frozen_a: assert property (conv_run_out && $past(conv_run_out) |-> $stable(mux_out))
        else $error("mux changed during conversion");
    end_after_run_a: assert property (conv_end_out |-> $past(conv_run_out) &&
        !$past(conv_end_out)) else $error("end pulse without conversion");
    irq_clear_a: assert property (vector_ack_in |=> !done_irq_out || conv_end_out)
        else $error("vector ack did not clear done");

    cover property (wr_ctrl && wb_dat_in[6]);
    cover property (conv_end_out);
    cover property (wr_ctrl && !wb_dat_in[7] && conv_run_out);
    cover property (vector_ack_in && done_irq_out);
endmodule // acc_ctrl_monitor

bind acc_ctrl acc_ctrl_monitor u_acc_ctrl_monitor (.mclk_in(mclk_in), .rst_in(rst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .trigger_in(trigger_in), .vector_ack_in(vector_ack_in),
    .mux_out(mux_out), .conv_run_out(conv_run_out), .sample_out(sample_out),
    .conv_end_out(conv_end_out), .done_irq_out(done_irq_out));

// file: acc_afe_model.sv
`timescale 1ns/1ps
// ==========
// Front end stand-in: trigger source and result counter
module acc_afe_model
    import acc_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic fire_in,
    input wire logic sample_in,
    input wire logic conv_end_in,
    output logic trigger_out,
    output logic [7:0] end_cnt_out
);
    logic [2:0] hold_r;
    logic [7:0] end_cnt_r;
    // Trigger held several cycles so the two-flop synchroniser cannot miss it
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            hold_r <= 3'h0;
        end else if (fire_in) begin
            hold_r <= 3'h4;
        end else if (hold_r != 3'h0) begin
            hold_r <= hold_r - 3'h1;
        end
    end
    // A result only counts while the converter is powered
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            end_cnt_r <= 8'h00;
        end else if (conv_end_in && sample_in) begin
            end_cnt_r <= end_cnt_r + 8'h01;
        end
    end
    assign trigger_out = !rst_in && (hold_r != 3'h0);
    assign end_cnt_out = end_cnt_r;
endmodule // acc_afe_model

// file: acc_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module acc_ctrl_tb;
    import acc_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, vack = 1'b0, fire = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, run, smp, cend, irq, trig;
    logic [7:0] q, ends;
    acc_mux_t mux;
    int fails = 0;
    int n_compared = 0;
    int n, k;
    // Reference settling time, 1 ms at 50 MHz
    localparam int SETTLE_CYC = 50000;
    always #10 mclk_in = ~mclk_in;
    acc_ctrl u_acc_ctrl (.mclk_in(mclk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .trigger_in(trig), .vector_ack_in(vack), .mux_out(mux),
        .conv_run_out(run), .sample_out(smp), .conv_end_out(cend), .done_irq_out(irq));
    acc_afe_model u_acc_afe_model (.mclk_in(mclk_in), .rst_in(rst_in), .fire_in(fire),
        .sample_in(smp), .conv_end_in(cend), .trigger_out(trig), .end_cnt_out(ends));
    // ==========
    // Tasks
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge mclk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        // Ack stands for one whole cycle: look mid-cycle, release at its closing edge
        for (i = 0; i < 20; i++) begin
            @(negedge mclk_in);
            if (ack === 1'b1) begin
                q = rdat[7:0];
                break;
            end
        end
        @(posedge mclk_in);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (i == 20) begin
            fails++;
            complete_run();
        end
    endtask
    // Counts cycles from busy seen high to the end pulse; accepts e within d plus three cycles either way
    task automatic expect_len(input int e, input int d);
        int i;
        n = 0;
        for (i = 0; i < 20 && run !== 1'b1; i++) @(negedge mclk_in);
        for (i = 0; i < 4000 && cend !== 1'b1; i++) begin
            @(negedge mclk_in);
            n++;
        end
        `CHK(n >= e - d - 3 && n <= e + d + 3, 1'b1)
        if (i == 4000) complete_run();
    endtask
    task automatic mux_chk(input logic [5:0] c, input acc_src_t p, input acc_src_t ng,
        input logic [2:0] f);
        wb(1'b1, ACC_CHSEL_OFF, {2'b00, c});
        repeat (2) @(posedge mclk_in);
        `CHK({mux.pos, mux.diff, mux.gain20, mux.temp_en}, {p, f})
        if (f[2]) `CHK(mux.neg, ng)
    endtask
    // ==========
    // Sequence
    initial begin
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        wb(1'b0, ACC_CTRL_A_OFF, 8'h00);
        `CHK(q, ACC_CTRL_A_RST)
        wb(1'b0, ACC_CHSEL_OFF, 8'h00);
        `CHK(q, ACC_CHSEL_RST)
        wb(1'b1, 8'h0b, 8'hff);
        wb(1'b0, 8'h0b, 8'h00);
        `CHK(q, 8'h00)
        for (k = 0; k < 8; k++) mux_chk(k[5:0], acc_src_t'(k), ACC_SRC_IN0, 3'b000);
        mux_chk(ACC_CH_GND, ACC_SRC_GND, ACC_SRC_IN0, 3'b000);
        mux_chk(ACC_CH_REF, ACC_SRC_REF, ACC_SRC_IN0, 3'b000);
        mux_chk(ACC_CH_TEMP, ACC_SRC_TEMP, ACC_SRC_IN0, 3'b001);
        mux_chk(6'h08, ACC_SRC_IN0, ACC_SRC_IN1, 3'b100);
        mux_chk(6'h09, ACC_SRC_IN0, ACC_SRC_IN1, 3'b110);
        mux_chk(6'h28, ACC_SRC_IN1, ACC_SRC_IN0, 3'b100);
        mux_chk(6'h12, ACC_SRC_IN3, ACC_SRC_IN4, 3'b100);
        mux_chk(6'h3f, ACC_SRC_IN7, ACC_SRC_IN6, 3'b110);
        mux_chk(6'h23, ACC_SRC_IN0, ACC_SRC_IN0, 3'b110);
        mux_chk(6'h24, ACC_SRC_IN3, ACC_SRC_IN3, 3'b100);
        mux_chk(6'h26, ACC_SRC_IN7, ACC_SRC_IN7, 3'b100);
        wb(1'b1, ACC_CTRL_A_OFF, 8'h80);
        `CHK(smp, 1'b1)
        wb(1'b1, ACC_CTRL_A_OFF, 8'hc0);
        expect_len(50, 2);
        wb(1'b0, ACC_CTRL_A_OFF, 8'h00);
        `CHK(q, 8'h90)
        wb(1'b1, ACC_CTRL_A_OFF, 8'h90);
        wb(1'b0, ACC_CTRL_A_OFF, 8'h00);
        `CHK(q, 8'h80)
        wb(1'b1, ACC_CTRL_A_OFF, 8'hc0);
        expect_len(26, 2);
        wb(1'b1, ACC_CTRL_A_OFF, 8'hc0);
        wb(1'b1, ACC_CHSEL_OFF, 8'h05);
        `CHK(mux.pos, ACC_SRC_IN7)
        wb(1'b1, ACC_CTRL_A_OFF, 8'h80);
        wb(1'b0, ACC_CTRL_A_OFF, 8'h00);
        `CHK(q[6], 1'b1)
        expect_len(15, 14);
        repeat (2) @(posedge mclk_in);
        `CHK(mux.pos, ACC_SRC_IN5)
        wb(1'b1, ACC_CTRL_A_OFF, 8'hc0);
        wb(1'b1, ACC_CTRL_A_OFF, 8'h00);
        `CHK(run, 1'b0)
        wb(1'b1, ACC_CTRL_A_OFF, 8'hc0);
        expect_len(50, 2);
        wb(1'b1, ACC_CTRL_A_OFF, 8'hc3);
        expect_len(104, 8);
        wb(1'b1, ACC_CTRL_A_OFF, 8'hc1);
        expect_len(26, 2);
        wb(1'b1, ACC_CTRL_A_OFF, 8'h88);
        `CHK(irq, 1'b1)
        vack <= 1'b1;
        @(posedge mclk_in);
        vack <= 1'b0;
        @(posedge mclk_in);
        `CHK(irq, 1'b0)
        wb(1'b1, ACC_CTRL_A_OFF, 8'ha0);
        fire <= 1'b1;
        @(posedge mclk_in);
        fire <= 1'b0;
        expect_len(26, 2);
        wb(1'b1, ACC_TRIG_OFF, 8'h01);
        wb(1'b1, ACC_CTRL_A_OFF, 8'he0);
        expect_len(26, 2);
        @(posedge mclk_in);
        expect_len(26, 2);
        wb(1'b1, ACC_CTRL_A_OFF, 8'h00);
        `CHK(ends, 8'd9)
        wb(1'b1, ACC_CHSEL_OFF, 8'h09);
        wb(1'b1, ACC_CTRL_A_OFF, 8'hc0);
        expect_len(50, 2);
        wb(1'b1, ACC_CHSEL_OFF, 8'h21);
        repeat (SETTLE_CYC) @(posedge mclk_in);
        wb(1'b1, ACC_CTRL_A_OFF, 8'hc0);
        expect_len(26, 2);
        `CHK(mux.pos, ACC_SRC_REF)
        complete_run();
    end
endmodule // acc_ctrl_tb
